// ===== nco_pkg.sv
// Constants shared by both ends of the parallel tuning-word load port.
// Assumes a single 200 MHz clock on both ends; pins cross as async levels.
`default_nettype none

package nco_pkg;
  // ==========================================================
  // Widths
  localparam int DATA_W   = 16;
  localparam int ADDR_W   = 3;
  localparam int TUNE_W   = 32;
  localparam int OFFSET_W = 12;
  localparam int DAC_W    = 10;
  localparam int PIN_W    = 6 + ADDR_W + DATA_W;

  // ==========================================================
  // Destination address codes
  localparam logic [2:0] ADDR_TUNE_A_LO = 3'h0;
  localparam logic [2:0] ADDR_TUNE_A_HI = 3'h1;
  localparam logic [2:0] ADDR_TUNE_B_LO = 3'h2;
  localparam logic [2:0] ADDR_TUNE_B_HI = 3'h3;
  localparam logic [2:0] ADDR_OFFSET_0  = 3'h4;
  localparam logic [2:0] ADDR_OFFSET_1  = 3'h5;
  localparam logic [2:0] ADDR_OFFSET_2  = 3'h6;
  localparam logic [2:0] ADDR_OFFSET_3  = 3'h7;

  // ==========================================================
  // Reset values
  localparam logic [31:0] TUNE_RESET   = 32'h0000_0000;
  localparam logic [11:0] OFFSET_RESET = 12'h000;
  localparam logic [31:0] ACC_RESET    = 32'h0000_0000;
  localparam logic [9:0]  DAC_MID      = 10'h200;
  // Pin idle levels: strobe, reset, sleep high; rest low
  localparam logic [24:0] PIN_IDLE     = 25'h1C0_0000;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int WR_LOW_NS     = 10;
  localparam int WR_LOW_CYC    =
    (WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Data held past strobe rise: covers the two-flop delay
  localparam int WR_HOLD_CYC   = 3;
  localparam int CNT_W         = 4;
endpackage

`default_nettype wire

// ===== nco_if.sv
// Pin bundle of the parallel load port and its select/control pins.
// Host drives every pin; the device only listens.
`default_nettype none

interface nco_if;
  logic [15:0] data;
  logic [2:0]  addr;
  logic        wr_n;
  logic        tuning_select;
  logic        offset_select_lo;
  logic        offset_select_hi;
  logic        sleep_n;
  logic        reset_n;

  modport device
  (
    input data, addr, wr_n, tuning_select,
    input offset_select_lo, offset_select_hi, sleep_n, reset_n
  );
  modport host
  (
    output data, addr, wr_n, tuning_select,
    output offset_select_lo, offset_select_hi, sleep_n, reset_n
  );
endinterface

`default_nettype wire

// ===== nco_host.sv
// Host end: turns write requests into strobed parallel writes.
// Assumes the device synchronises all pins with two flip-flops.
`default_nettype none

module nco_host
  import nco_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  nco_if.host              pins,
  input  wire logic        req_valid,
  input  wire logic [2:0]  req_addr,
  input  wire logic [15:0] req_data,
  output logic             req_ready,
  input  wire logic        tune_sel,
  input  wire logic [1:0]  off_sel,
  input  wire logic        sleep_req,
  input  wire logic        nco_reset_req
);
  typedef enum logic [1:0]
  {
    H_IDLE  = 2'b00,
    H_SETUP = 2'b01,
    H_LOW   = 2'b10,
    H_HOLD  = 2'b11
  } host_state_e;

  host_state_e      state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [15:0]      data_r;
  logic [2:0]       addr_r;
  logic             wr_n_r;
  logic             ctrl_r [0:4];

  // ==========================================================
  // Write sequencer
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= H_IDLE;
      cnt_r   <= '0;
      data_r  <= 16'h0000;
      addr_r  <= 3'h0;
      wr_n_r  <= 1'b1;
    end
    else
    begin
      case (state_r)
        H_IDLE:
        begin
          if (req_valid)
          begin
            data_r  <= req_data;
            addr_r  <= req_addr;
            state_r <= H_SETUP;
          end
        end
        H_SETUP:
        begin
          wr_n_r  <= 1'b0;
          cnt_r   <= CNT_W'(WR_LOW_CYC - 1);
          state_r <= H_LOW;
        end
        H_LOW:
        begin
          if (cnt_r == '0)
          begin
            // Data stays put past the rise for the sync delay
            wr_n_r  <= 1'b1;
            cnt_r   <= CNT_W'(WR_HOLD_CYC - 1);
            state_r <= H_HOLD;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        end
        H_HOLD:
        begin
          if (cnt_r == '0)
            state_r <= H_IDLE;
          else
            cnt_r <= cnt_r - 1'b1;
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Ready and control pins, all registered
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      req_ready <= 1'b0;
    else
      req_ready <= (state_r == H_IDLE) && !req_valid;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_r[0] <= 1'b0;
      ctrl_r[1] <= 1'b0;
      ctrl_r[2] <= 1'b0;
      ctrl_r[3] <= 1'b1;
      ctrl_r[4] <= 1'b1;
    end
    else
    begin
      // Changes land on our edge; device sync absorbs it
      ctrl_r[0] <= tune_sel;
      ctrl_r[1] <= off_sel[0];
      ctrl_r[2] <= off_sel[1];
      ctrl_r[3] <= !sleep_req;
      ctrl_r[4] <= !nco_reset_req;
    end
  end

  assign pins.data             = data_r;
  assign pins.addr             = addr_r;
  assign pins.wr_n             = wr_n_r;
  assign pins.tuning_select    = ctrl_r[0];
  assign pins.offset_select_lo = ctrl_r[1];
  assign pins.offset_select_hi = ctrl_r[2];
  assign pins.sleep_n          = ctrl_r[3];
  assign pins.reset_n          = ctrl_r[4];
endmodule

`default_nettype wire

// ===== nco_device.sv
// Device end: tuning/offset registers, phase accumulator, sine, DAC code.
// Assumes all pins are asynchronous to the clock; each gets two flops.
`default_nettype none

module nco_device
  import nco_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       nrst,
  nco_if.device           pins,
  output logic [9:0]      dac_code,
  output logic            dac_enable,
  output logic            reference_output_enable
);
  // ==========================================================
  // Sine lookup: parabolic half-wave, offset binary
  function automatic logic [9:0] sine_lookup(input logic [11:0] ph);
    logic [10:0] h;
    logic [21:0] prod;
    logic [10:0] mag;
    logic [8:0]  amp;
    h    = ph[10:0];
    prod = 22'(h) * 22'(12'h800 - {1'b0, h});
    mag  = prod[21:11];
    // Peak 512 would overflow the top half; clip to 511
    amp  = (mag > 11'h1FF) ? 9'h1FF : mag[8:0];
    if (ph[11])
      sine_lookup = DAC_MID - {1'b0, amp};
    else
      sine_lookup = DAC_MID + {1'b0, amp};
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic [24:0] pin_raw;
  logic [24:0] sync1_r;
  logic [24:0] sync2_r;
  logic        wr_prev_r;

  assign pin_raw =
  {
    pins.wr_n, pins.reset_n, pins.sleep_n, pins.tuning_select,
    pins.offset_select_hi, pins.offset_select_lo, pins.addr,
    pins.data
  };

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_r <= PIN_IDLE;
      sync2_r <= PIN_IDLE;
    end
    else
    begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
    end
  end

  logic        wr_n_s;
  logic        reset_n_s;
  logic        awake_s;
  logic        tune_sel_s;
  logic [1:0]  off_sel_s;
  logic [2:0]  addr_s;
  logic [15:0] data_s;

  assign wr_n_s     = sync2_r[24];
  assign reset_n_s  = sync2_r[23];
  assign awake_s    = sync2_r[22];
  assign tune_sel_s = sync2_r[21];
  assign off_sel_s  = sync2_r[20:19];
  assign addr_s     = sync2_r[18:16];
  assign data_s     = sync2_r[15:0];

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      wr_prev_r <= 1'b1;
    else
      wr_prev_r <= wr_n_s;
  end

  // One pulse per strobe rise, so a write loads once
  logic wr_rise;
  assign wr_rise = wr_n_s && !wr_prev_r && awake_s;

  // ==========================================================
  // Destination registers
  logic [31:0] tuning_word_a_r;
  logic [31:0] tuning_word_b_r;
  logic [11:0] phase_offset_r [0:3];

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      tuning_word_a_r <= TUNE_RESET;
      tuning_word_b_r <= TUNE_RESET;
    end
    else if (wr_rise)
    begin
      case (addr_s)
        ADDR_TUNE_A_LO: tuning_word_a_r[15:0]  <= data_s;
        ADDR_TUNE_A_HI: tuning_word_a_r[31:16] <= data_s;
        ADDR_TUNE_B_LO: tuning_word_b_r[15:0]  <= data_s;
        ADDR_TUNE_B_HI: tuning_word_b_r[31:16] <= data_s;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      phase_offset_r[0] <= OFFSET_RESET;
      phase_offset_r[1] <= OFFSET_RESET;
      phase_offset_r[2] <= OFFSET_RESET;
      phase_offset_r[3] <= OFFSET_RESET;
    end
    else if (wr_rise && addr_s[2])
      phase_offset_r[addr_s[1:0]] <= data_s[11:0];
  end

  // ==========================================================
  // Phase accumulator
  logic [31:0] acc_r;
  logic [31:0] tune_step;

  assign tune_step = tune_sel_s ? tuning_word_b_r
                                : tuning_word_a_r;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      acc_r <= ACC_RESET;
    else if (!reset_n_s)
      acc_r <= ACC_RESET;
    else if (awake_s)
      acc_r <= acc_r + tune_step;
  end

  // ==========================================================
  // Offset, truncation, sine, DAC code
  logic [11:0] lut_addr;

  // Offset goes on the top bits; the rest is dropped
  assign lut_addr = acc_r[31:20]
                  + phase_offset_r[off_sel_s];

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      dac_code <= DAC_MID;
    else if (awake_s)
      dac_code <= sine_lookup(lut_addr);
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      dac_enable              <= 1'b0;
      reference_output_enable <= 1'b0;
    end
    else
    begin
      dac_enable              <= awake_s;
      reference_output_enable <= awake_s;
    end
  end
endmodule

`default_nettype wire

// ===== nco_props.sv
// Checker for the parallel load pins between host and device ends.
// Assumes it sits beside the interface and sees its signals directly.
`default_nettype none

module nco_props
(
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic [15:0] data,
  input wire logic [2:0]  addr,
  input wire logic        wr_n,
  input wire logic        tuning_select,
  input wire logic        offset_select_lo,
  input wire logic        offset_select_hi,
  input wire logic        sleep_n,
  input wire logic        reset_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Strobe and bus timing, and idle pin levels after reset
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  strobe_pulse_a:
    assert property ($fell(wr_n) |=> !wr_n ##1 wr_n)
    else $error("Strobe low time wrong");
  strobe_gap_a:
    assert property ($rose(wr_n) |-> wr_n[*4])
    else $error("Strobe high time too short");
  fall_spacing_a:
    assert property ($fell(wr_n) |-> $past(wr_n, 2))
    else $error("Strobe fell too soon");
  bus_setup_a:
    assert property ($fell(wr_n) |-> $stable(data) && $stable(addr))
    else $error("Bus moved at strobe fall");
  bus_low_stable_a:
    assert property (!wr_n |-> $stable({data, addr}))
    else $error("Bus moved while strobe low");
  // Hold covers the device's two-flop delay
  bus_hold_a:
    assert property ($rose(wr_n) |-> ($stable(data) && $stable(addr))[*3])
    else $error("Bus moved after strobe rise");
  bus_lead_a:
    assert property ($changed({data, addr}) |=> $fell(wr_n))
    else $error("Bus change not followed by strobe");
  reset_idle_a:
    assert property ($rose(nrst) |-> wr_n && sleep_n && reset_n
      && !tuning_select && !offset_select_lo && !offset_select_hi
      && data == 16'h0000 && addr == 3'h0)
    else $error("Pins not idle after reset");
endmodule

`default_nettype wire

// ===== testbench.sv
// Testbench: host and device ends joined by the pin interface.
// Assumes the hand-over latencies: a write loads 6 edges after taken.
`default_nettype none

`define CHECK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("Error %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module testbench
  import nco_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Signals
  logic        clock;
  logic        nrst;
  logic        req_valid;
  logic [2:0]  req_addr;
  logic [15:0] req_data;
  logic        req_ready;
  logic        tune_sel;
  logic [1:0]  off_sel;
  logic        sleep_req;
  logic        nco_reset_req;
  logic [9:0]  dac_code;
  logic        dac_enable;
  logic        ref_en;
  logic [9:0]  hold_code;
  int          errors;
  int          total_checks;
  int          cycles;
  logic [15:0] off_val [4] = '{16'hF400, 16'h0800, 16'h0C00, 16'h0200};
  logic [9:0]  off_exp [4] = '{10'h3FF, 10'h200, 10'h001, 10'h380};

  nco_if pins ();
  nco_host nco_host_i (.clock(clock), .nrst(nrst), .pins(pins),
    .req_valid(req_valid), .req_addr(req_addr), .req_data(req_data),
    .req_ready(req_ready), .tune_sel(tune_sel), .off_sel(off_sel),
    .sleep_req(sleep_req), .nco_reset_req(nco_reset_req));
  nco_device nco_device_i (.clock(clock), .nrst(nrst), .pins(pins),
    .dac_code(dac_code), .dac_enable(dac_enable),
    .reference_output_enable(ref_en));
  nco_props nco_props_i (.clock(clock), .nrst(nrst), .data(pins.data),
    .addr(pins.addr), .wr_n(pins.wr_n),
    .tuning_select(pins.tuning_select),
    .offset_select_lo(pins.offset_select_lo),
    .offset_select_hi(pins.offset_select_hi),
    .sleep_n(pins.sleep_n), .reset_n(pins.reset_n));

  // ==========================================================
  // Tasks
  task automatic stop_test();
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [2:0] ad, input logic [15:0] d);
    int n;
    @(negedge clock);
    req_valid = 1'b1;
    req_addr = ad;
    req_data = d;
    @(negedge clock);
    req_valid = 1'b0;
    n = 0;
    while (req_ready !== 1'b1 && n < 20)
    begin
      @(negedge clock);
      n++;
    end
    `CHECK(req_ready, 1'b1)
    // Load has landed; accumulate and code stages still to land
    repeat (6) @(negedge clock);
  endtask

  task automatic sel(input logic t, input logic [1:0] o);
    @(negedge clock);
    tune_sel = t;
    off_sel = o;
    repeat (6) @(negedge clock);
  endtask

  // Two codes half a turn apart sum to twice midscale
  task automatic pair(input int gap, input logic [10:0] sum);
    @(negedge clock);
    hold_code = dac_code;
    repeat (gap) @(negedge clock);
    `CHECK({1'b0, hold_code} + {1'b0, dac_code}, sum)
  endtask

  // ==========================================================
  // Clock and timeout
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial
  begin
    cycles = 0;
    forever
    begin
      @(posedge clock);
      cycles++;
      if (cycles == 2000)
      begin
        errors++;
        stop_test();
      end
    end
  end

  // ==========================================================
  // Tests
  initial
  begin
    nrst = 1'b0;
    req_valid = 1'b0;
    req_addr = 3'h0;
    req_data = 16'h0000;
    tune_sel = 1'b0;
    off_sel = 2'h0;
    sleep_req = 1'b0;
    nco_reset_req = 1'b0;
    errors = 0;
    total_checks = 0;
    repeat (16) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    `CHECK(dac_code, DAC_MID)
    `CHECK({dac_enable, ref_en}, 2'b11)
    $display("Test reset state done");
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_OFFSET_0 | 3'(i), off_val[i]);
      sel(1'b0, 2'(i));
      `CHECK(dac_code, off_exp[i])
    end
    $display("Test phase offsets done");
    sel(1'b0, 2'h0);
    wr(ADDR_TUNE_B_HI, 16'h8000);
    pair(1, 11'h7FE);
    sel(1'b1, 2'h0);
    pair(1, 11'h400);
    wr(ADDR_TUNE_A_HI, 16'h4000);
    sel(1'b0, 2'h0);
    pair(2, 11'h400);
    $display("Test tuning words done");
    nco_reset_req = 1'b1;
    repeat (6) @(negedge clock);
    pair(1, 11'h7FE);
    nco_reset_req = 1'b0;
    sleep_req = 1'b1;
    repeat (6) @(negedge clock);
    `CHECK({dac_enable, ref_en}, 2'b00)
    // Refused while asleep; a zero word would stop the steps
    wr(ADDR_TUNE_A_HI, 16'h0000);
    pair(3, 11'h7FE);
    sleep_req = 1'b0;
    repeat (6) @(negedge clock);
    pair(2, 11'h400);
    $display("Test clear and sleep done");
    nrst = 1'b0;
    @(negedge clock);
    `CHECK(dac_code, DAC_MID)
    nrst = 1'b1;
    repeat (8) @(negedge clock);
    pair(1, 11'h400);
    $display("Test second reset done");
    wr(ADDR_TUNE_A_LO, 16'hFFFF);
    wr(ADDR_TUNE_A_HI, 16'hFFFF);
    wr(ADDR_TUNE_B_LO, 16'hFFFF);
    wr(ADDR_TUNE_B_HI, 16'hFFFF);
    // Step of minus one keeps the phase just under zero
    for (int t = 0; t < 2; t++)
    begin
      nco_reset_req = 1'b1;
      sel(1'(t), 2'h0);
      nco_reset_req = 1'b0;
      pair(40, 11'h400);
    end
    $display("Test low halves done");
    stop_test();
  end
endmodule

`default_nettype wire
